// *** shared/csl_pkg.sv ***
// Shared constants and types for the configuration shadow loader.
// Assumes a 24-bit word-addressed program flash with word addresses stepping by two.
package csl_pkg;

    // Flash word and address geometry
    localparam int CSL_AW = 24;
    localparam int CSL_DW = 24;
    localparam int CSL_NWORDS = 6;
    localparam logic [CSL_AW-1:0] CSL_WORD_STEP = 24'h000002;

    // Lowest loaded word address per memory size (32K..512K)
    localparam logic [CSL_AW-1:0] CSL_BASE_32K = 24'h0057F0;
    localparam logic [CSL_AW-1:0] CSL_BASE_64K = 24'h00AFF0;
    localparam logic [CSL_AW-1:0] CSL_BASE_128K = 24'h0157F0;
    localparam logic [CSL_AW-1:0] CSL_BASE_256K = 24'h02AFF0;
    localparam logic [CSL_AW-1:0] CSL_BASE_512K = 24'h0557F0;

    // Memory size codes
    localparam logic [2:0] CSL_SIZE_32K = 3'h0;
    localparam logic [2:0] CSL_SIZE_64K = 3'h1;
    localparam logic [2:0] CSL_SIZE_128K = 3'h2;
    localparam logic [2:0] CSL_SIZE_256K = 3'h3;
    localparam logic [2:0] CSL_SIZE_512K = 3'h4;

    // Load order index of each word
    localparam logic [2:0] CSL_IDX_DEBUG = 3'h0;
    localparam logic [2:0] CSL_IDX_RESET_OPT = 3'h1;
    localparam logic [2:0] CSL_IDX_WATCHDOG = 3'h2;
    localparam logic [2:0] CSL_IDX_OSC = 3'h3;
    localparam logic [2:0] CSL_IDX_OSC_SEL = 3'h4;
    localparam logic [2:0] CSL_IDX_GEN_SEG = 3'h5;

    // Register port offsets
    localparam logic [15:0] CSL_OFS_RESERVED_A = 16'h57EC;
    localparam logic [15:0] CSL_OFS_RESERVED_B = 16'h57EE;
    localparam logic [15:0] CSL_OFS_DEBUG = 16'h57F0;
    localparam logic [15:0] CSL_OFS_RESET_OPT = 16'h57F2;
    localparam logic [15:0] CSL_OFS_WATCHDOG = 16'h57F4;
    localparam logic [15:0] CSL_OFS_OSC = 16'h57F6;
    localparam logic [15:0] CSL_OFS_OSC_SEL = 16'h57F8;
    localparam logic [15:0] CSL_OFS_GEN_SEG = 16'h57FA;
    localparam logic [15:0] CSL_OFS_STATUS = 16'h5800;
    localparam logic [15:0] CSL_OFS_CONTROL = 16'h5802;

    // Unimplemented upper bits read as ones
    localparam logic [15:0] CSL_UPPER_ONES = 16'hFFFF;
    localparam logic [7:0] CSL_SHADOW_RESET = 8'h00;

    // Field positions
    localparam int CSL_BIT_BSCAN_EN = 5;
    localparam int CSL_BIT_ALT_TW2 = 5;
    localparam int CSL_BIT_ALT_TW1 = 4;
    localparam int CSL_BIT_WDT_HW_EN = 7;
    localparam int CSL_BIT_WDT_WIN_DIS = 6;
    localparam int CSL_BIT_PLL_WAIT = 5;
    localparam int CSL_BIT_WDT_PRE = 4;
    localparam int CSL_BIT_REMAP_LOCK = 5;
    localparam int CSL_BIT_OSC_IO = 2;
    localparam int CSL_BIT_CODE_PROT = 1;
    localparam int CSL_BIT_WRITE_PROT = 0;
    localparam int CSL_BIT_STAT_DONE = 0;
    localparam int CSL_BIT_STAT_BUSY = 1;
    localparam int CSL_BIT_CTRL_RELOAD = 0;

    // Flash read request
    typedef struct packed {
        logic rd;
        logic [CSL_AW-1:0] addr;
    } csl_flash_req_t;

    // Decoded configuration fields
    typedef struct packed {
        logic codeProtectAll;
        logic writeProtectAll;
        logic boundaryScanEnable;
        logic [1:0] debugChannelSelect;
        logic altPinsTwoWireOne;
        logic altPinsTwoWireTwo;
        logic watchdogHwEnable;
        logic watchdogWindowDisable;
        logic pllLockWaitEnable;
        logic watchdogPrescaleSelect;
        logic [1:0] clockSwitchMonitorMode;
        logic pinRemapOneWayLock;
        logic oscPinIoFunction;
        logic [1:0] primaryOscMode;
    } csl_fields_t;

endpackage : csl_pkg

// *** core/csl_flash_reader.sv ***
// Sequencer that fetches the configuration words from program flash.
// Assumes flash answers each read with one flashValid pulse, any latency later.
`timescale 1ns/10ps
`default_nettype none
module csl_flash_reader
    import csl_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control
    input wire logic start,
    input wire logic [CSL_AW-1:0] baseAddr,
    // Flash port
    output csl_flash_req_t flashReq,
    input wire logic flashValid,
    input wire logic [CSL_DW-1:0] flashData,
    // Loaded words
    output logic wordValid,
    output logic [2:0] wordIdx,
    output logic [7:0] wordData,
    output logic done
);

    typedef enum logic [1:0] {RD_IDLE, RD_ISSUE, RD_WAIT} csl_rd_state_t;

    csl_rd_state_t state_reg;
    logic [2:0] idx_reg;
    logic [CSL_AW-1:0] base_reg;
    logic lastWord;

    // Request is a handshake, so it may stay combinational
    assign lastWord = (idx_reg == 3'(CSL_NWORDS - 1));
    assign flashReq.rd = (state_reg == RD_ISSUE);
    assign flashReq.addr = base_reg + CSL_AW'(idx_reg) * CSL_WORD_STEP;

    // One word at a time; restart wins over a read in flight
    always_ff @(posedge clk)
    begin
        wordValid <= 1'b0;
        done <= 1'b0;
        if (rst)
        begin
            state_reg <= RD_IDLE;
            idx_reg <= 3'h0;
            base_reg <= CSL_BASE_32K;
            wordIdx <= 3'h0;
            wordData <= CSL_SHADOW_RESET;
        end
        else if (start)
        begin
            state_reg <= RD_ISSUE;
            idx_reg <= 3'h0;
            base_reg <= baseAddr;
        end
        else
        begin
            case (state_reg)
                RD_ISSUE: state_reg <= RD_WAIT;
                RD_WAIT:
                    if (flashValid)
                    begin
                        wordValid <= 1'b1;
                        wordIdx <= idx_reg;
                        wordData <= flashData[7:0]; // Upper bits unimplemented
                        idx_reg <= idx_reg + 3'h1;
                        done <= lastWord;
                        state_reg <= lastWord ? RD_IDLE : RD_ISSUE;
                    end
                default: state_reg <= RD_IDLE;
            endcase
        end
    end

endmodule : csl_flash_reader
`default_nettype wire

// *** core/config_shadow_loader.sv ***
// Configuration shadow loader: copies flash configuration words into shadow registers.
// Assumes a synchronous reset and a flash read port that answers with a valid pulse.
// Consumers must stay in reset while dependentResetHold is high.
//
// Overview of operation
// - Settings live only in volatile shadow flops, restored from flash after power-up.
// - During reset every configuration word is copied into its shadow register.
// - The copy repeats on every reset kind, not only power-on.
// - Words come from flash top; base set by memory size, debug word lowest.
// - Bits 23 to 8 are unimplemented; ones written there change nothing.
// - Erased last page loads as zeros, which turns code protection on.
// - Code-protect bit zero protects all program memory; one leaves it open.
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module config_shadow_loader
    import csl_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Other reset sources (watchdog, software, brown-out, pin)
    input wire logic resetReq,
    // Device memory size code
    input wire logic [2:0] memSize,
    // Program flash read port
    output csl_flash_req_t flashReq,
    input wire logic flashValid,
    input wire logic [CSL_DW-1:0] flashData,
    // Register port
    input wire logic [15:0] regAddr,
    input wire logic [15:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [CSL_DW-1:0] regRdata,
    // Consumers of the shadow values
    output logic dependentResetHold,
    output csl_fields_t cfgFields
);

    typedef enum logic [1:0] {LD_START, LD_BUSY, LD_READY} csl_ld_state_t;

    // Base of the configuration words for a memory size
    // Unknown size codes fall back to the smallest part, the safe choice
    function automatic logic [CSL_AW-1:0] cfgBase(input logic [2:0] size);
        logic [CSL_AW-1:0] base;
        base = CSL_BASE_32K;
        if (size == CSL_SIZE_64K)
            base = CSL_BASE_64K;
        else if (size == CSL_SIZE_128K)
            base = CSL_BASE_128K;
        else if (size == CSL_SIZE_256K)
            base = CSL_BASE_256K;
        else if (size == CSL_SIZE_512K)
            base = CSL_BASE_512K;
        return base;
    endfunction : cfgBase

    // Read view of a shadow byte, unimplemented bits as ones
    function automatic logic [CSL_DW-1:0] shadowView(input logic [7:0] value);
        return {CSL_UPPER_ONES, value};
    endfunction : shadowView

    csl_ld_state_t state_reg;
    logic [7:0] shadow_reg [CSL_NWORDS];
    logic loaded_reg;
    logic released_reg;
    logic [CSL_DW-1:0] rdata_reg;
    logic softReload;
    logic startLoad;
    logic wordValid;
    logic [2:0] wordIdx;
    logic [7:0] wordData;
    logic loadDone;

    // Software reset through the control register counts as a reset too
    // It acts at the edge it is taken, exactly like a pulse on resetReq
    assign softReload = regWr && (regAddr == CSL_OFS_CONTROL) && regWdata[CSL_BIT_CTRL_RELOAD];
    assign startLoad = (state_reg == LD_START);

    csl_flash_reader reader (
        .clk(clk),
        .rst(rst),
        .start(startLoad),
        .baseAddr(cfgBase(memSize)),
        .flashReq(flashReq),
        .flashValid(flashValid),
        .flashData(flashData),
        .wordValid(wordValid),
        .wordIdx(wordIdx),
        .wordData(wordData),
        .done(loadDone)
    );

    // Load sequencer; any reset source sends it back to the start
    // A read still in flight is abandoned and the reader restarts at word 0
    always_ff @(posedge clk)
    begin
        if (rst)
            state_reg <= LD_START;
        else if (resetReq || softReload)
            state_reg <= LD_START;
        else
        begin
            case (state_reg)
                LD_START: state_reg <= LD_BUSY;
                LD_BUSY: state_reg <= loadDone ? LD_READY : LD_BUSY;
                default: state_reg <= LD_READY;
            endcase
        end
    end

    // Shadows only change from flash; the port cannot write them
    // No reset here: the shadows are volatile and only a completed load defines them
    always_ff @(posedge clk)
    begin
        if (wordValid)
            shadow_reg[wordIdx] <= wordData;
    end

    // Set once the last word of a pass lands
    always_ff @(posedge clk)
    begin
        if (rst || resetReq || softReload)
            loaded_reg <= 1'b0;
        else if (loadDone && state_reg == LD_BUSY)
            loaded_reg <= 1'b1;
    end

    // Consumers leave reset one cycle after the last word lands, when the
    // registered fields below already carry the loaded shadows
    always_ff @(posedge clk)
    begin
        if (rst || resetReq || softReload)
            released_reg <= 1'b0;
        else
            released_reg <= loaded_reg;
    end

    // Hold consumers in reset while shadows or decoded fields may be stale
    assign dependentResetHold = rst || !released_reg;

    // Fields decode only from loaded shadows; before that they read protective zeros
    logic [7:0] dbgW;
    logic [7:0] porW;
    logic [7:0] wdtW;
    logic [7:0] oscW;
    logic [7:0] gsW;
    assign dbgW = loaded_reg ? shadow_reg[CSL_IDX_DEBUG] : CSL_SHADOW_RESET;
    assign porW = loaded_reg ? shadow_reg[CSL_IDX_RESET_OPT] : CSL_SHADOW_RESET;
    assign wdtW = loaded_reg ? shadow_reg[CSL_IDX_WATCHDOG] : CSL_SHADOW_RESET;
    assign oscW = loaded_reg ? shadow_reg[CSL_IDX_OSC] : CSL_SHADOW_RESET;
    assign gsW = loaded_reg ? shadow_reg[CSL_IDX_GEN_SEG] : CSL_SHADOW_RESET;

    // A zero bit means protected, so an erased page protects everything
    // Registered, so the fields take the loaded shadows one cycle after the last word
    always_ff @(posedge clk)
    begin
        if (rst)
            cfgFields <= '0;
        else
        begin
            cfgFields.codeProtectAll <= !gsW[CSL_BIT_CODE_PROT];
            cfgFields.writeProtectAll <= !gsW[CSL_BIT_WRITE_PROT];
            cfgFields.boundaryScanEnable <= dbgW[CSL_BIT_BSCAN_EN];
            cfgFields.debugChannelSelect <= dbgW[1:0];
            cfgFields.altPinsTwoWireOne <= porW[CSL_BIT_ALT_TW1];
            cfgFields.altPinsTwoWireTwo <= porW[CSL_BIT_ALT_TW2];
            cfgFields.watchdogHwEnable <= wdtW[CSL_BIT_WDT_HW_EN];
            cfgFields.watchdogWindowDisable <= wdtW[CSL_BIT_WDT_WIN_DIS];
            cfgFields.pllLockWaitEnable <= wdtW[CSL_BIT_PLL_WAIT];
            cfgFields.watchdogPrescaleSelect <= wdtW[CSL_BIT_WDT_PRE];
            cfgFields.clockSwitchMonitorMode <= oscW[7:6];
            cfgFields.pinRemapOneWayLock <= oscW[CSL_BIT_REMAP_LOCK];
            cfgFields.oscPinIoFunction <= oscW[CSL_BIT_OSC_IO];
            cfgFields.primaryOscMode <= oscW[1:0];
        end
    end

    // Read decode; reserved words read as all ones
    logic [CSL_DW-1:0] rdMux;
    logic [CSL_DW-1:0] statusWord;
    // Bit 0 follows the release of consumers, so software never sees loaded with stale fields
    assign statusWord = {22'h000000, (state_reg != LD_READY || !released_reg), released_reg};
    always_comb
    begin
        if (regAddr == CSL_OFS_RESERVED_A || regAddr == CSL_OFS_RESERVED_B)
            rdMux = shadowView(8'hFF);
        else if (regAddr == CSL_OFS_DEBUG)
            rdMux = shadowView(dbgW);
        else if (regAddr == CSL_OFS_RESET_OPT)
            rdMux = shadowView(porW);
        else if (regAddr == CSL_OFS_WATCHDOG)
            rdMux = shadowView(wdtW);
        else if (regAddr == CSL_OFS_OSC)
            rdMux = shadowView(oscW);
        else if (regAddr == CSL_OFS_OSC_SEL)
            rdMux = shadowView(loaded_reg ? shadow_reg[CSL_IDX_OSC_SEL] : CSL_SHADOW_RESET);
        else if (regAddr == CSL_OFS_GEN_SEG)
            rdMux = shadowView(gsW);
        else if (regAddr == CSL_OFS_STATUS)
            rdMux = statusWord;
        else
            rdMux = '0; // Unmapped reads as zero
    end

    // Read data stands only in the cycle after the strobe
    // Cleared between reads so a stale value never looks like an answer
    always_ff @(posedge clk)
    begin
        if (rst || !regRd)
            rdata_reg <= '0;
        else
            rdata_reg <= rdMux;
    end
    assign regRdata = rdata_reg;

endmodule : config_shadow_loader
`default_nettype wire

// *** tb/csl_loader_assertions.sv ***
// Port checks for the configuration shadow loader.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module csl_loader_assertions
    import csl_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Reset events and size
    input wire logic resetReq,
    input wire logic [2:0] memSize,
    // Flash port
    input wire csl_flash_req_t flashReq,
    input wire logic flashValid,
    input wire logic [CSL_DW-1:0] flashData,
    // Register port
    input wire logic [15:0] regAddr,
    input wire logic [15:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [CSL_DW-1:0] regRdata,
    // Consumers
    input wire logic dependentResetHold,
    input wire csl_fields_t cfgFields
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // Base of the word block; unknown size codes fall back to the smallest
    wire logic [CSL_AW-1:0] baseAddr = (memSize == CSL_SIZE_64K) ? CSL_BASE_64K :
        (memSize == CSL_SIZE_128K) ? CSL_BASE_128K : (memSize == CSL_SIZE_256K) ? CSL_BASE_256K :
        (memSize == CSL_SIZE_512K) ? CSL_BASE_512K : CSL_BASE_32K;
    wire logic cfgRead = regRd && !regAddr[0] && regAddr >= CSL_OFS_DEBUG && regAddr <= CSL_OFS_GEN_SEG;
    wire logic rsvRead = regRd && (regAddr == CSL_OFS_RESERVED_A || regAddr == CSL_OFS_RESERVED_B);
    wire logic swReload = regWr && regAddr == CSL_OFS_CONTROL && regWdata[CSL_BIT_CTRL_RELOAD];
    // First fetch of a fresh pass
    sequence seqFirstFetch;
        ##[1:4] (flashReq.rd && flashReq.addr == baseAddr);
    endsequence
    AST_HOLD_IN_RST: assert property (disable iff (1'b0) rst |-> dependentResetHold)
        else $error("hold low in reset");
    AST_NO_FETCH_IN_RST: assert property (disable iff (1'b0) rst |-> !flashReq.rd)
        else $error("fetch in reset");
    AST_FETCH_AFTER_RST: assert property ($fell(rst) |-> seqFirstFetch)
        else $error("no fetch after reset");
    AST_FETCH_ON_REQ: assert property (resetReq || swReload |-> seqFirstFetch)
        else $error("no fetch after reset event");
    AST_FETCH_RANGE: assert property (flashReq.rd |-> flashReq.addr[CSL_AW-1:4] == baseAddr[CSL_AW-1:4]
        && flashReq.addr[3:0] <= 4'hA && !flashReq.addr[0]) else $error("fetch address off map");
    AST_RD_PULSE: assert property (flashReq.rd |=> !flashReq.rd)
        else $error("read strobe too long");
    AST_HOLD_RELEASE: assert property ($fell(dependentResetHold) |-> $past(flashValid, 3))
        else $error("hold fell without a flash answer");
    AST_HOLD_ON_REQ: assert property (resetReq |=> dependentResetHold)
        else $error("hold not raised by reset event");
    AST_IDLE_RDATA: assert property (!$past(regRd) |-> regRdata == 24'h000000)
        else $error("read data outside its cycle");
    AST_RSV_READ: assert property (rsvRead |=> regRdata == 24'hFFFFFF)
        else $error("reserved word not all ones");
    AST_CFG_UPPER: assert property (cfgRead |=> regRdata[CSL_DW-1:8] == CSL_UPPER_ONES)
        else $error("upper bits not ones");
    AST_STATUS_LOADED: assert property (regRd && regAddr == CSL_OFS_STATUS |=>
        regRdata[CSL_BIT_STAT_DONE] == !$past(dependentResetHold)) else $error("status disagrees with hold");
    AST_FIELDS_SETTLED: assert property (!dependentResetHold && !$past(dependentResetHold) |->
        $stable(cfgFields)) else $error("fields changed after release");
endmodule : csl_loader_assertions
bind config_shadow_loader csl_loader_assertions u_chk (.clk(clk), .rst(rst), .resetReq(resetReq),
    .memSize(memSize), .flashReq(flashReq), .flashValid(flashValid), .flashData(flashData), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .dependentResetHold(dependentResetHold), .cfgFields(cfgFields));
`default_nettype wire

// *** tb/csl_flash_model.sv ***
// Program flash model answering configuration word reads.
// Assumes the word block ends in F0..FA, so address bits 3:1 pick the word.
`timescale 1ns/10ps
`default_nettype none
module csl_flash_model
    import csl_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Read port
    input wire csl_flash_req_t flashReq,
    output logic flashValid,
    output logic [CSL_DW-1:0] flashData,
    // Latency choice
    input wire logic slow
);
    // Only configuration words are held; no code lives there
    logic [CSL_DW-1:0] wordMem [0:7];
    int waitCnt = 0;
    logic [2:0] wordSel = 3'h0;
    initial flashValid = 1'b0;
    initial flashData = 24'h000000;
    // One answer per read; data churns when not valid so stale values never match
    always @(posedge clk)
    begin
        flashValid <= (waitCnt == 1) && !flashReq.rd; // A superseded read is never answered
        flashData <= (waitCnt == 1) ? wordMem[wordSel] : ~flashData;
        if (rst)
            waitCnt <= 0; // A device reset abandons the read in flight
        else if (flashReq.rd)
        begin
            waitCnt <= slow ? 1 + $urandom % 5 : 1;
            wordSel <= flashReq.addr[3:1];
        end
        else if (waitCnt != 0)
            waitCnt <= waitCnt - 1;
    end
endmodule : csl_flash_model
`default_nettype wire

// *** tb/config_shadow_loader_tb.sv ***
// Self-checking bench for the configuration shadow loader.
// Assumes the flash model and the bound port checker beside the design.
`timescale 1ns/10ps
`default_nettype none
module config_shadow_loader_tb
    import csl_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic resetReq = 1'b0;
    logic slow = 1'b0;
    logic [2:0] memSize = 3'h0;
    logic [15:0] regAddr = 16'h0000;
    logic [15:0] regWdata = 16'h0000;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    csl_flash_req_t flashReq;
    logic flashValid;
    logic [23:0] flashData;
    logic [23:0] regRdata;
    logic dependentResetHold;
    csl_fields_t cfgFields;
    int n_fail = 0;
    int checks = 0;
    logic [23:0] img [0:5];
    initial forever #2.5 clk = ~clk;
    config_shadow_loader uut (.clk(clk), .rst(rst), .resetReq(resetReq), .memSize(memSize), .flashReq(flashReq),
        .flashValid(flashValid), .flashData(flashData), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .dependentResetHold(dependentResetHold), .cfgFields(cfgFields));
    csl_flash_model flash (.clk(clk), .rst(rst), .flashReq(flashReq), .flashValid(flashValid),
        .flashData(flashData), .slow(slow));
    task check(input logic [23:0] seen, input logic [23:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task summarize;
        $display("Counts: %0d checks, %0d mismatches", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : summarize
    task reg_read(input logic [15:0] a, output logic [23:0] d);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1 d = regRdata;
    endtask : reg_read
    task reg_write(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWr <= 1'b0;
    endtask : reg_write
    // Start a load: 0 device reset, 1 reset event, 2 software reload
    task trigger(input int how);
        if (how == 1)
        begin
            @(posedge clk);
            resetReq <= 1'b1;
            @(posedge clk);
            resetReq <= 1'b0;
        end
        else if (how == 2)
            reg_write(CSL_OFS_CONTROL, 16'h0001);
        else
        begin
            @(posedge clk);
            rst <= 1'b1;
            repeat (4) @(posedge clk);
            rst <= 1'b0;
        end
    endtask : trigger
    // New image; erase gives zeros, odd passes scramble the unimplemented upper bits
    // Only pass 4 stands for an erased last page; no other scenario wipes the image
    task fill(input int p);
        for (int i = 0; i < 6; i++)
        begin
            img[i] = (p == 4) ? 24'h000000 : {(p % 2) ? 16'($urandom) : CSL_UPPER_ONES, 8'($urandom)};
            if (p != 4 && i == 0)
                img[i][7:0] = (img[i][7:0] | 8'h88) & 8'hEF; // Reserved debug bits fixed
            if (p != 4 && i == 1)
                img[i][3] = 1'b1; // Reserved reset option bit fixed
            flash.wordMem[i] = img[i];
        end
    endtask : fill
    // Zero protect bits mean protected, so an erased page locks the part
    function automatic csl_fields_t exp_fields();
        return {~img[5][1], ~img[5][0], img[0][5], img[0][1:0], img[1][4], img[1][5], img[2][7:4],
            img[3][7:5], img[3][2], img[3][1:0]};
    endfunction : exp_fields
    // Bounded wait for the hold to drop, then two cycles for the decode
    task wait_loaded;
        @(posedge clk) #1;
        for (int i = 0; i < 300 && dependentResetHold !== 1'b0; i++)
            @(posedge clk) #1;
        check({23'h000000, dependentResetHold}, 24'h000000);
        repeat (2) @(posedge clk);
    endtask : wait_loaded
    task check_image;
        logic [23:0] d;
        for (int i = 0; i < 6; i++)
        begin
            reg_read(CSL_OFS_DEBUG + 16'(2 * i), d);
            check(d, {CSL_UPPER_ONES, img[i][7:0]});
        end
        check({7'h00, cfgFields}, {7'h00, exp_fields()});
        reg_read(CSL_OFS_STATUS, d);
        check(d, 24'h000001);
    endtask : check_image
    initial
    begin
        logic [23:0] d;
        void'($urandom(32'h5080));
        // Every size code, each trigger, both latencies, an erased page
        for (int p = 0; p < 6; p++)
        begin
            @(posedge clk);
            memSize <= (p == 5) ? 3'h7 : 3'(p);
            slow <= p[0];
            fill(p);
            trigger(p % 3);
            wait_loaded();
            check_image();
            $display("Test %0d done", p);
        end
        // Reserved, unmapped, and ones written into shadow words
        reg_read(CSL_OFS_RESERVED_A, d);
        check(d, 24'hFFFFFF);
        reg_read(CSL_OFS_RESERVED_B, d);
        check(d, 24'hFFFFFF);
        reg_read(16'h1234, d);
        check(d, 24'h000000);
        reg_write(CSL_OFS_DEBUG, 16'hFFFF);
        reg_write(CSL_OFS_GEN_SEG, 16'hFFFF);
        check_image();
        $display("Test 6 done");
        // Device reset in mid-load restarts the pass
        fill(1);
        slow <= 1'b1;
        trigger(1);
        repeat (6) @(posedge clk);
        reg_read(CSL_OFS_STATUS, d);
        check(d, 24'h000002);
        trigger(0);
        wait_loaded();
        check_image();
        $display("Test 7 done");
        summarize();
    end
    // Watchdog well beyond the few hundred cycles the tests need
    initial
    begin
        #100000;
        n_fail++;
        summarize();
    end
endmodule : config_shadow_loader_tb
`default_nettype wire
